// ### rtl/lci_pkg.sv
// package of constants and carrier types for the cutoff interlock sequencer
package lci_pkg;

	// timing
	localparam int unsigned ClkMhz = 100;
	localparam int unsigned StartSec = 187;
	localparam int unsigned EndSec = 6;
	localparam int unsigned DestructOnSec = 17;
	localparam int unsigned WindowOffMs = 50;
	localparam int unsigned EdsOnDeciSec = 89;
	localparam int unsigned StaggerMs = 100;
	localparam int unsigned CyclesPerMs = ClkMhz * 1000;
	localparam int unsigned StaggerCycles = StaggerMs * CyclesPerMs;

	// count of automatic cutoff interlocks
	localparam int unsigned NumAuto = 6;
	localparam int unsigned NumEng = 5;

	// register byte offsets
	localparam logic [7:0] RegCtrl = 8'h00;
	localparam logic [7:0] RegStatus = 8'h04;
	localparam logic [7:0] RegIrqStat = 8'h08;
	localparam logic [7:0] RegIrqMask = 8'h0C;
	localparam logic [7:0] RegCause = 8'h10;
	localparam logic [7:0] RegTime = 8'h14;

	// ctrl bits
	localparam int unsigned CtrlArm = 0;
	localparam int unsigned CtrlRearm = 1;

	// interrupt bit positions
	localparam int unsigned IrqStart = 0;
	localparam int unsigned IrqCutoff = 1;
	localparam int unsigned IrqDone = 2;
	localparam int unsigned IrqW = 3;

	// cause bit positions
	localparam int unsigned CauseManual = 0;
	localparam int unsigned CauseStage = 1;
	localparam int unsigned CauseFuel = 2;
	localparam int unsigned CauseSupply = 3;
	localparam int unsigned CauseVolt = 4;
	localparam int unsigned CauseEds = 5;
	localparam int unsigned CauseIu = 6;
	localparam int unsigned CauseW = 7;

	// engine masks: bit0 = engine 1
	localparam logic [4:0] GroupNormalFirst = 5'h15;
	localparam logic [4:0] GroupPreferFirst = 5'h1A;
	localparam logic [4:0] AllEngines = 5'h1F;
	localparam logic [4:0] PreferTrigger = 5'h0A;

	localparam logic [31:0] ZeroWord = 32'h00000000;

	typedef enum logic [3:0] {
		LciIdle = 4'h1,
		LciRun = 4'h2,
		LciCut = 4'h4,
		LciDone = 4'h8
	} lci_state_t;

	// sensor inputs from the stage, instrument unit and spacecraft
	typedef struct packed {
		logic manualCutoff;
		logic umbilicalSep;
		logic prepComplete;
		logic fireEnable;
		logic internalShutdown;
		logic [1:0] destructFault;
		logic [4:0] fuelValveA;
		logic [4:0] fuelValveB;
		logic hypergolRupture;
		logic supplyFault;
		logic stageMainBusFault;
		logic stageInstrBusFault;
		logic [2:0] scManualCutoff;
		logic [2:0] votingBusOk;
		logic iuReady;
	} lci_sense_t;

	typedef struct packed {
		lci_state_t state;
		logic armed;
		logic [31:0] cycCnt;
		logic [31:0] tenths;
		logic [CauseW-1:0] cause;
		logic [4:0] shutdown;
		logic [4:0] secondGroup;
		logic [31:0] stagger;
		logic [IrqW-1:0] irqStat;
		logic [IrqW-1:0] irqMask;
		logic ack;
		logic [31:0] rdat;
	} lci_regs_t;

endpackage : lci_pkg

// ### rtl/lci_sequencer.sv
// terminal countdown sequencer with start and cutoff interlocks
`timescale 1ns/100ps

// What this block does
// - start on count pulse when three interlocks active
// - run automatically from start to plus six
// - preparation summation is AND of readiness inputs
// - no hold; only a cutoff stops it
// - manual cutoff honoured start to umbilical separation
// - any of six automatic interlocks stops it
// - internal shutdown or destruct fault cuts off
// - destruct check only minus seventeen to minus fifty
// - fuel valve premature or mismatched opening cuts off
// - three engines first, two after 100 ms
// - engine 2 or 4 fault: 2,4,5 first
// - otherwise 1,3,5 first then 2,4
// - sequencer supply fault cuts off
// - main or instrumentation bus fault cuts off
// - emergency detection armed minus 8.9 to minus fifty
// - instrument unit ready loss cuts off same window
module lci_sequencer import lci_pkg::*; #(
	parameter int unsigned StaggerLen = StaggerCycles,
	parameter int unsigned TenthLen = CyclesPerMs * 100,
	parameter int unsigned ReadyWidth = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// countdown clock start pulse
	input wire logic startPulse,
	// readiness conditions summed into preparation complete
	input wire logic [ReadyWidth-1:0] readyItems,
	// stage, instrument unit and spacecraft pins
	input wire lci_sense_t sense,
	// outputs
	output logic [4:0] engineShutdown,
	output logic cutoffCmd,
	output logic running,
	output logic irq
);

	localparam logic [31:0] StartTenths = 32'(StartSec * 10);
	localparam logic [31:0] EndTenths = 32'((StartSec + EndSec) * 10);
	localparam logic [31:0] DestructOn = 32'((StartSec - DestructOnSec) * 10);
	localparam logic [31:0] EdsOn = 32'(StartSec * 10 - EdsOnDeciSec);
	// minus fifty ms falls inside the last tenth before zero; half a tenth kept as cycle count
	localparam logic [31:0] WinOffTenths = 32'(StartSec * 10 - 1);
	localparam logic [31:0] WinOffCyc = 32'(TenthLen / 2);
	localparam logic [31:0] TenthLast = 32'(TenthLen - 1);
	localparam logic [31:0] StaggerLast = 32'(StaggerLen - 1);

	// pin inputs pass two flops before use
	lci_sense_t senseM, senseS;
	logic startM, startS, startS2;
	logic [ReadyWidth-1:0] readyM, readyS;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			senseM <= '0;
			senseS <= '0;
			startM <= 1'b0;
			startS <= 1'b0;
			startS2 <= 1'b0;
			readyM <= '0;
			readyS <= '0;
		end else begin
			senseM <= sense;
			senseS <= senseM;
			startM <= startPulse;
			startS <= startM;
			startS2 <= startS;
			readyM <= readyItems;
			readyS <= readyM;
		end
	end

	lci_regs_t q, d;

	logic prepOk, startEdge, inRun, destructWin, edsWin;
	logic stageCut, fuelCut, voltCut, edsCut, iuCut, manualCut;
	logic [4:0] fuelBad;
	logic [CauseW-1:0] newCause;
	logic anyCut, busReq, wrStb;
	logic [IrqW-1:0] events;

	assign prepOk = &readyS;
	assign startEdge = startS & ~startS2;
	assign inRun = (q.state == LciRun);
	assign destructWin = (q.tenths >= DestructOn) &&
		((q.tenths < WinOffTenths) || (q.tenths == WinOffTenths && q.cycCnt < WinOffCyc));
	assign edsWin = (q.tenths >= EdsOn) &&
		((q.tenths < WinOffTenths) || (q.tenths == WinOffTenths && q.cycCnt < WinOffCyc));

	assign manualCut = senseS.manualCutoff & ~senseS.umbilicalSep;
	assign stageCut = senseS.internalShutdown | (destructWin & (|senseS.destructFault));
	assign fuelBad = (senseS.fuelValveA & senseS.fuelValveB & {NumEng{~senseS.hypergolRupture}}) |
		(senseS.fuelValveA ^ senseS.fuelValveB);
	assign fuelCut = |fuelBad;
	assign voltCut = senseS.stageMainBusFault | senseS.stageInstrBusFault;
	assign edsCut = edsWin & ((|senseS.scManualCutoff) | ~(&senseS.votingBusOk));
	assign iuCut = edsWin & ~senseS.iuReady;

	always_comb begin
		newCause = '0;
		newCause[CauseManual] = manualCut;
		newCause[CauseStage] = stageCut;
		newCause[CauseFuel] = fuelCut;
		newCause[CauseSupply] = senseS.supplyFault;
		newCause[CauseVolt] = voltCut;
		newCause[CauseEds] = edsCut;
		newCause[CauseIu] = iuCut;
	end
	assign anyCut = |newCause;

	assign busReq = wb_cyc_i & wb_stb_i & ~q.ack;
	assign wrStb = busReq & wb_we_i & wb_sel_i[0];

	always_comb begin
		d = q;
		events = '0;
		d.ack = busReq;
		// run timekeeping in tenths of a second since start
		if (inRun) begin
			if (q.cycCnt == TenthLast) begin
				d.cycCnt = ZeroWord;
				d.tenths = q.tenths + 32'h00000001;
			end else begin
				d.cycCnt = q.cycCnt + 32'h00000001;
			end
		end
		unique case (q.state)
			LciIdle: begin
				if (startEdge && q.armed && prepOk && senseS.fireEnable) begin
					d.state = LciRun;
					d.cycCnt = ZeroWord;
					d.tenths = ZeroWord;
					d.cause = '0;
					events[IrqStart] = 1'b1;
				end
			end
			LciRun: begin
				// no hold path: only cutoff or completion leaves this state
				if (anyCut) begin
					d.state = LciCut;
					d.cause = newCause;
					d.stagger = ZeroWord;
					events[IrqCutoff] = 1'b1;
					if (fuelCut && (|(fuelBad & PreferTrigger)) && !(|(fuelBad & ~PreferTrigger))) begin
						d.shutdown = GroupPreferFirst;
						d.secondGroup = AllEngines & ~GroupPreferFirst;
					end else begin
						d.shutdown = GroupNormalFirst;
						d.secondGroup = AllEngines & ~GroupNormalFirst;
					end
				end else if (q.tenths >= EndTenths) begin
					d.state = LciDone;
					events[IrqDone] = 1'b1;
				end
			end
			LciCut: begin
				if (q.secondGroup != 5'h00) begin
					if (q.stagger == StaggerLast) begin
						d.shutdown = AllEngines;
						d.secondGroup = 5'h00;
					end else begin
						d.stagger = q.stagger + 32'h00000001;
					end
				end
			end
			LciDone: begin
			end
		endcase
		// bus writes
		if (wrStb) begin
			unique case (wb_adr_i)
				RegCtrl: begin
					d.armed = wb_dat_i[CtrlArm];
					if (wb_dat_i[CtrlRearm] && q.state != LciRun) begin
						d.state = LciIdle;
						d.shutdown = 5'h00;
						d.secondGroup = 5'h00;
					end
				end
				RegIrqStat: d.irqStat = q.irqStat & ~wb_dat_i[IrqW-1:0];
				RegIrqMask: d.irqMask = wb_dat_i[IrqW-1:0];
				default: begin
				end
			endcase
		end
		// set wins over clear
		d.irqStat = d.irqStat | events;
		d.rdat = ZeroWord;
		if (busReq && !wb_we_i) begin
			unique case (wb_adr_i)
				RegCtrl: d.rdat[0] = q.armed;
				RegStatus: d.rdat = {27'h0, prepOk, q.state};
				RegIrqStat: d.rdat[IrqW-1:0] = q.irqStat;
				RegIrqMask: d.rdat[IrqW-1:0] = q.irqMask;
				RegCause: d.rdat = {19'h0, q.shutdown, 1'b0, q.cause};
				RegTime: d.rdat = q.tenths;
				default: d.rdat = ZeroWord;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '{state: LciIdle, default: '0};
		end else begin
			q <= d;
		end
	end

	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdat;
	assign engineShutdown = q.shutdown;
	assign cutoffCmd = (q.state == LciCut);
	assign running = inRun;
	assign irq = |(q.irqStat & q.irqMask);

endmodule : lci_sequencer

// ### verification/lci_sequencer_assertions.sv
// bound checker of bus answers, start and cutoff behaviour of the sequencer
`timescale 1ns/100ps
module lci_sequencer_checker import lci_pkg::*; #(
	parameter int unsigned StaggerLen = 20,
	parameter int unsigned TenthLen = 10,
	parameter int unsigned ReadyWidth = 8
) (
	// clock, reset and bus
	input wire logic clk, input wire logic arst_n,
	input wire logic wb_cyc_i, input wire logic wb_stb_i, input wire logic wb_we_i, input wire logic wb_ack_o,
	// pins and outputs
	input wire logic [ReadyWidth-1:0] readyItems, input wire lci_sense_t sense,
	input wire logic [4:0] engineShutdown, input wire logic cutoffCmd, input wire logic running
);
	logic [31:0] cutCnt_q;
	logic [63:0] runCnt_q;
	// shortest run that may end without a cutoff: the whole count up to plus six
	localparam logic [63:0] RunMin = 64'(StartSec + EndSec) * 64'hA * 64'(TenthLen);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// cycles spent in cutoff; wide enough for the full-length stagger too
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) cutCnt_q <= '0;
		else cutCnt_q <= cutoffCmd ? cutCnt_q + 32'h1 : '0;
	end
	// cycles spent running; 64 bits so the full-length count cannot wrap
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) runCnt_q <= '0;
		else runCnt_q <= running ? runCnt_q + 64'h1 : '0;
	end
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
	a_start_ready: assert property ($rose(running) |-> $past(&readyItems, 3) && $past(sense.fireEnable, 3))
		else $error("start without interlocks");
	a_no_hold: assert property ((running |-> !cutoffCmd) and ($fell(running) |-> cutoffCmd || runCnt_q >= RunMin))
		else $error("run stopped without cutoff");
	a_cut_latched: assert property (cutoffCmd && !(wb_cyc_i && wb_we_i) |=> cutoffCmd) else $error("cutoff dropped");
	a_fault_cut: assert property (running && (sense.supplyFault || sense.stageMainBusFault
		|| sense.stageInstrBusFault || sense.internalShutdown) |-> ##[1:6] cutoffCmd) else $error("fault not cut off");
	a_first_group: assert property (cutoffCmd && cutCnt_q < StaggerLen - 1 |-> $countones(engineShutdown) == 3)
		else $error("first group wrong");
	a_second_group: assert property (cutoffCmd && cutCnt_q > StaggerLen + 1 |-> engineShutdown == AllEngines)
		else $error("second group missing");
endmodule : lci_sequencer_checker
bind lci_sequencer lci_sequencer_checker #(.StaggerLen(StaggerLen), .TenthLen(TenthLen), .ReadyWidth(ReadyWidth))
	lci_sequencer_checker_inst (
	.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .readyItems, .sense, .engineShutdown, .cutoffCmd, .running);

// ### verification/lci_vehicle_model.sv
// model of the stage, instrument unit and spacecraft pins
`timescale 1ns/100ps
module lci_vehicle_model import lci_pkg::*; (
	// clock
	input wire logic clk,
	// wanted levels and instrument unit health
	input wire lci_sense_t want,
	input wire logic iuHealthy,
	input wire logic ignitionCmd,
	// pins
	output lci_sense_t sense
);
	always_ff @(posedge clk) begin
		sense <= want;
		sense.iuReady <= iuHealthy && ignitionCmd;
	end
endmodule : lci_vehicle_model

// ### verification/lci_sequencer_bench.sv
// self-checking bench of the cutoff interlock sequencer
`timescale 1ns/100ps
module lci_sequencer_bench import lci_pkg::*; ;
	localparam int StagLen = 20;
	logic clk, arst_n, wbCyc, wbStb, wbWe, wbAck, startPulse, iuHealthy, cutoffCmd, running, irq;
	logic [7:0] wbAdr, readyItems;
	logic [31:0] wbDatI, wbDatO, rd;
	logic [31:0] seed = 32'h6098AEA5;
	logic [4:0] engineShutdown;
	logic [3:0] wbSel;
	lci_sense_t want, base, sense;
	int badCount, nChecks;
	lci_sequencer #(.StaggerLen(StagLen), .TenthLen(10)) lci_sequencer_inst (.clk, .arst_n, .wb_cyc_i(wbCyc),
		.wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
		.wb_ack_o(wbAck), .startPulse, .readyItems, .sense, .engineShutdown, .cutoffCmd, .running, .irq);
	lci_vehicle_model lci_vehicle_model_inst (.clk, .want, .iuHealthy, .ignitionCmd(1'b1), .sense);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// cause bits plus the first shutdown group for each injected fault
	function automatic logic [31:0] expCause(input int k);
		return {19'h0, (k == 2) ? GroupPreferFirst : GroupNormalFirst, 1'b0,
			7'(7'h01 << ((k == 8) ? CauseStage : (k < 3) ? k : k - 1))};
	endfunction : expCause
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			badCount++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	// ack is read before the edge's own updates land, so it is the sampled value
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDatI <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		r = wbDatO;
		chk(wbAck, 1);
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic go(input logic [31:0] expRun);
		wb(1, RegCtrl, 32'h3, rd);
		repeat (3) @(posedge clk);
		startPulse <= 1'b1;
		repeat (4) @(posedge clk);
		startPulse <= 1'b0;
		repeat (6) @(posedge clk);
		chk(running, expRun);
	endtask : go
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (90000) @(posedge clk);
		badCount++;
		tally_and_finish();
	end
	initial begin
		arst_n = 1'b0;
		{wbCyc, wbStb, wbWe, startPulse, wbAdr, wbDatI, readyItems} = '0;
		wbSel = 4'hF;
		iuHealthy = 1'b1;
		base = '0;
		base.fireEnable = 1'b1;
		base.votingBusOk = 3'h7;
		want = base;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		wb(0, RegStatus, 0, rd);
		chk(rd, 32'h1);
		wb(0, 8'h20, 0, rd);
		chk(rd, ZeroWord);
		wb(1, RegIrqMask, 32'h2, rd);
		wb(0, RegIrqMask, 0, rd);
		chk(rd, 32'h2);
		// a write without the low byte lane must leave the mask alone
		wbSel <= 4'h0;
		wb(1, RegIrqMask, 32'h5, rd);
		wbSel <= 4'hF;
		wb(0, RegIrqMask, 0, rd);
		chk(rd, 32'h2);
		readyItems <= 8'hFF ^ 8'(8'h01 << (rnd() % 8));
		go(0);
		readyItems <= 8'hFF;
		want.fireEnable <= 1'b0;
		go(0);
		want.fireEnable <= 1'b1;
		for (int k = 0; k < 9; k++) begin
			go(1);
			if (k > 5) repeat (17900) @(posedge clk);
			chk(irq, 0);
			case (k)
				0: want.manualCutoff <= 1'b1;
				1: want.internalShutdown <= 1'b1;
				2: want.fuelValveA <= 5'h02;
				3: want.fuelValveB <= 5'h04;
				4: want.supplyFault <= 1'b1;
				5: want.stageMainBusFault <= 1'b1;
				6: want.votingBusOk <= 3'h7 ^ 3'(3'h1 << (rnd() % 3));
				7: iuHealthy <= 1'b0;
				default: want.destructFault <= 2'h2;
			endcase
			repeat (6) @(posedge clk);
			want <= base;
			iuHealthy <= 1'b1;
			chk(cutoffCmd, 1);
			wb(0, RegCause, 0, rd);
			chk(rd, expCause(k));
			repeat (StagLen + 5) @(posedge clk);
			chk(engineShutdown, AllEngines);
			chk(cutoffCmd, 1);
			chk(irq, 1);
			wb(1, RegIrqStat, 32'h7, rd);
			chk(irq, 0);
		end
		go(1);
		want.umbilicalSep <= 1'b1;
		want.manualCutoff <= 1'b1;
		want.destructFault <= 2'h1;
		want.scManualCutoff <= 3'h4;
		iuHealthy <= 1'b0;
		repeat (10) @(posedge clk);
		chk(cutoffCmd, 0);
		want <= base;
		iuHealthy <= 1'b1;
		// past minus fifty ms the destruct, emergency and ready checks are all disarmed
		repeat (18800) @(posedge clk);
		want.destructFault <= 2'h2;
		want.votingBusOk <= 3'h3;
		iuHealthy <= 1'b0;
		repeat (10) @(posedge clk);
		chk(cutoffCmd, 0);
		want <= base;
		iuHealthy <= 1'b1;
		repeat (580) @(posedge clk);
		wb(0, RegStatus, 0, rd);
		chk(rd, 32'h18);
		chk(engineShutdown, 0);
		tally_and_finish();
	end
endmodule : lci_sequencer_bench
